//--- core/scsw_core.sv
// System clock source selection and glitch-free switch with AHB-Lite registers.
// Assumes oscillator clocks and ready levels arrive asynchronously on pins.
//
// Operation
// - wait falling edge of old clock
// - powered-down target oscillator started with delay
// - hold output low until new rises
// - status refreshed once new clock active
// - same oscillator switches without start-up delay
// - low-frequency switch syncs old and new
// - delays 2 us, 2 cycles, 1024 cycles
// - select 00 uses configuration default source
// - select 01 uses secondary crystal oscillator
// - select 1x uses internal block frequency
// - reset clears source select to zero
// - frequency selector decode, resets to 0111
// - codes 0010-1110 divide the fast oscillator
// - bit 5 high only on external clock
// - bit 5 ignores secondary oscillator use
// - bit 7 ready, or 1 when disabled
// - bits 4 and 1 show oscillator readiness
// - bit 0 shows fast oscillator stable, driving
// - unimplemented bits read zero, ignore writes
// - secondary oscillator enabled only by Timer1
// - slow oscillator off after switch, unless watchdog or power-up timer
// - slow oscillator kept for power-up, watchdog
module scsw_core
    import scsw_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        ext_clk_in,
    input  wire logic        sec_osc_clk,
    input  wire logic        hf_osc_clk,
    input  wire logic        lf_osc_clk,
    input  wire logic        hf_osc_running,
    input  wire logic        hf_osc_settled,
    input  wire logic        lf_osc_running,
    input  wire logic        sec_osc_ready,
    input  wire logic        secondary_osc_enable,
    input  wire logic        watchdog_enable,
    input  wire logic        power_up_timer_active,
    input  wire logic [1:0]  config_default_osc,
    output logic             hf_osc_enable,
    output logic             lf_osc_enable,
    output logic             sys_clk_out,
    output logic             switch_busy
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Postscaler exponent; zero means undivided: fast oscillator for code 1111, slow oscillator for codes 0000 and 0001
    function automatic logic [3:0] div_exp(input logic [3:0] sel);
        case (sel)
            4'hF:    div_exp = 4'h0;
            4'hE:    div_exp = 4'h1;
            4'hD:    div_exp = 4'h2;
            4'hC:    div_exp = 4'h3;
            4'hB:    div_exp = 4'h4;
            4'hA:    div_exp = 4'h5;
            4'h9:    div_exp = 4'h6;
            4'h8:    div_exp = 4'h7;
            4'h7:    div_exp = 4'h5;
            4'h6:    div_exp = 4'h6;
            4'h5:    div_exp = 4'h7;
            4'h4:    div_exp = 4'h8;
            4'h3,
            4'h2:    div_exp = 4'h9;
            default: div_exp = EXP_NONE;
        endcase
    endfunction

    // Level of a source as seen through the synchronisers
    function automatic logic clk_level(input scsw_src_type src, input logic [3:0] ex,
                                       input logic ext, input logic sec, input logic hf,
                                       input logic lf, input logic [POST_W-1:0] cnt);
        case (src)
            SRC_EXT: clk_level = ext;
            SRC_SEC: clk_level = sec;
            SRC_LF:  clk_level = lf;
            default: clk_level = (ex == EXP_NONE) ? hf : cnt[ex - 4'h1];
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic ext_lvl, ext_rise;
    logic sec_lvl, sec_rise;
    logic hf_lvl,  hf_rise;
    logic lf_lvl,  lf_rise;
    logic hf_run_s, hf_set_s, lf_run_s, sec_rdy_s, sec_en_s;

    scsw_sync u_sync_ext (.hclk(hclk), .hresetn(hresetn), .async_in(ext_clk_in),
                          .level(ext_lvl), .rise(ext_rise), .fall());
    scsw_sync u_sync_sec (.hclk(hclk), .hresetn(hresetn), .async_in(sec_osc_clk),
                          .level(sec_lvl), .rise(sec_rise), .fall());
    scsw_sync u_sync_hf  (.hclk(hclk), .hresetn(hresetn), .async_in(hf_osc_clk),
                          .level(hf_lvl), .rise(hf_rise), .fall());
    scsw_sync u_sync_lf  (.hclk(hclk), .hresetn(hresetn), .async_in(lf_osc_clk),
                          .level(lf_lvl), .rise(lf_rise), .fall());
    scsw_sync u_sync_hfr (.hclk(hclk), .hresetn(hresetn), .async_in(hf_osc_running),
                          .level(hf_run_s), .rise(), .fall());
    scsw_sync u_sync_hfs (.hclk(hclk), .hresetn(hresetn), .async_in(hf_osc_settled),
                          .level(hf_set_s), .rise(), .fall());
    scsw_sync u_sync_lfr (.hclk(hclk), .hresetn(hresetn), .async_in(lf_osc_running),
                          .level(lf_run_s), .rise(), .fall());
    scsw_sync u_sync_scr (.hclk(hclk), .hresetn(hresetn), .async_in(sec_osc_ready),
                          .level(sec_rdy_s), .rise(), .fall());
    scsw_sync u_sync_sce (.hclk(hclk), .hresetn(hresetn), .async_in(secondary_osc_enable),
                          .level(sec_en_s), .rise(), .fall());

    // ----------------------------------------------------------------
    // Registers and bus slave
    // ----------------------------------------------------------------
    logic [1:0]  clock_source_select_r;
    logic [3:0]  internal_freq_select_r;
    logic [7:0]  osc_status_r;
    logic [7:0]  osc_status_nxt;
    logic [31:0] hrdata_r;
    logic        wr_pend_r;
    logic [ADDR_LSB_W-1:0] wr_addr_r;
    logic        addr_phase;
    logic [7:0]  osc_control_rd;

    assign addr_phase     = hsel & htrans[1] & hready;
    assign osc_control_rd = {1'b0, internal_freq_select_r, 1'b0, clock_source_select_r};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= '0;
        end else if (hready) begin
            wr_pend_r <= addr_phase & hwrite;
            wr_addr_r <= haddr[ADDR_LSB_W-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clock_source_select_r  <= SCS_RESET;
            internal_freq_select_r <= INTERNAL_FREQ_SELECT_RESET;
        end else if (wr_pend_r && wr_addr_r == OSC_CONTROL_ADDR) begin
            // Bits 7 and 2 have no storage
            clock_source_select_r  <= hwdata[SCS_LSB +: 2];
            internal_freq_select_r <= hwdata[INTERNAL_FREQ_SELECT_LSB +: 4];
        end
    end

    // Read data is fetched in the address phase so hrdata is a flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h0000_0000;
        end else if (addr_phase && !hwrite) begin
            case (haddr[ADDR_LSB_W-1:0])
                OSC_CONTROL_ADDR: hrdata_r <= {24'h00_0000, osc_control_rd};
                OSC_STATUS_ADDR:  hrdata_r <= {24'h00_0000, osc_status_r};
                default:          hrdata_r <= 32'h0000_0000;
            endcase
        end
    end

    assign hrdata    = hrdata_r;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ----------------------------------------------------------------
    // Requested source
    // ----------------------------------------------------------------
    scsw_src_type req_src;
    logic [3:0]   req_exp;
    logic [3:0]   int_exp;
    scsw_src_type int_src;

    always_comb begin
        int_exp = div_exp(internal_freq_select_r);
        int_src = (int_exp == EXP_NONE && internal_freq_select_r != 4'hF) ? SRC_LF : SRC_HF;
        if (clock_source_select_r[1]) begin
            req_src = int_src;
            req_exp = int_exp;
        end else if (clock_source_select_r[0]) begin
            req_src = SRC_SEC;
            req_exp = EXP_NONE;
        end else if (config_default_osc == CONFIG_DEFAULT_OSC_INTERNAL) begin
            req_src = int_src;
            req_exp = int_exp;
        end else begin
            req_src = SRC_EXT;
            req_exp = EXP_NONE;
        end
    end

    // ----------------------------------------------------------------
    // Postscaler of the fast oscillator
    // ----------------------------------------------------------------
    logic [POST_W-1:0] post_cnt_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            post_cnt_r <= '0;
        end else if (hf_rise) begin
            post_cnt_r <= post_cnt_r + {{(POST_W-1){1'b0}}, 1'b1};
        end
    end

    // ----------------------------------------------------------------
    // Switch sequencer
    // ----------------------------------------------------------------
    scsw_state_type state_r;
    scsw_src_type   cur_src_r, tgt_src_r;
    logic [3:0]     cur_exp_r, tgt_exp_r;
    logic           cur_valid_r;
    logic [DLY_W-1:0] dly_r;
    logic           old_lvl, new_lvl, old_prev_r, new_prev_r;
    logic           old_fall, new_rise, dly_tick, need_start, change_req;
    logic           hf_en_r, lf_en_r, sys_clk_r;
    logic [DLY_W-1:0] dly_load;

    assign old_lvl  = clk_level(cur_src_r, cur_exp_r, ext_lvl, sec_lvl, hf_lvl, lf_lvl,
                                post_cnt_r);
    assign new_lvl  = clk_level(tgt_src_r, tgt_exp_r, ext_lvl, sec_lvl, hf_lvl, lf_lvl,
                                post_cnt_r);
    assign old_fall = old_prev_r & ~old_lvl;
    assign new_rise = new_lvl & ~new_prev_r;
    assign change_req = !cur_valid_r || req_src != cur_src_r || req_exp != cur_exp_r;

    // Start-up needed only when the target oscillator differs or is off
    always_comb begin
        case (req_src)
            SRC_HF:  need_start = !hf_en_r;
            SRC_LF:  need_start = !lf_en_r || cur_src_r != SRC_LF;
            default: need_start = !cur_valid_r || cur_src_r != req_src;
        endcase
        if (cur_valid_r && req_src == cur_src_r && req_src != SRC_LF) begin
            need_start = need_start & (req_src == SRC_HF);
        end
        case (req_src)
            SRC_HF:  dly_load = DLY_W'(HF_STARTUP_CYC);
            SRC_EXT: dly_load = DLY_W'(EXT_STARTUP_EDG);
            SRC_SEC: dly_load = DLY_W'(SEC_STARTUP_EDG);
            default: dly_load = DLY_W'(LF_STARTUP_EDG);
        endcase
    end

    // Fast oscillator delay runs in bus cycles, the others in their own edges
    always_comb begin
        case (tgt_src_r)
            SRC_HF:  dly_tick = 1'b1;
            SRC_EXT: dly_tick = ext_rise;
            SRC_SEC: dly_tick = sec_rise;
            default: dly_tick = lf_rise;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            old_prev_r <= 1'b0;
            new_prev_r <= 1'b0;
        end else begin
            old_prev_r <= old_lvl;
            new_prev_r <= new_lvl;
        end
    end

    // A rewrite while busy is only looked at again back in idle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r     <= ST_IDLE;
            tgt_src_r   <= SRC_EXT;
            tgt_exp_r   <= EXP_NONE;
            cur_src_r   <= SRC_EXT;
            cur_exp_r   <= EXP_NONE;
            cur_valid_r <= 1'b0;
            dly_r       <= '0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (change_req) begin
                        tgt_src_r <= req_src;
                        tgt_exp_r <= req_exp;
                        dly_r     <= dly_load;
                        if (need_start) begin
                            state_r <= ST_STARTUP;
                        end else begin
                            state_r <= cur_valid_r ? ST_FALL : ST_RISE;
                        end
                    end
                end
                ST_STARTUP: begin
                    if (dly_tick) begin
                        dly_r <= dly_r - {{(DLY_W-1){1'b0}}, 1'b1};
                        if (dly_r == {{(DLY_W-1){1'b0}}, 1'b1}) begin
                            state_r <= cur_valid_r ? ST_FALL : ST_RISE;
                        end
                    end
                end
                ST_FALL: begin
                    if (!old_lvl && !sys_clk_r) begin
                        state_r <= ST_RISE;
                    end
                end
                ST_RISE: begin
                    if (new_rise) begin
                        cur_src_r   <= tgt_src_r;
                        cur_exp_r   <= tgt_exp_r;
                        cur_valid_r <= 1'b1;
                        state_r     <= ST_UPDATE;
                    end
                end
                ST_UPDATE: begin
                    state_r <= ST_IDLE;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // System clock output
    // ----------------------------------------------------------------
    // Held low between the old fall and the new rise, so no runt pulse
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sys_clk_r <= 1'b0;
        end else begin
            case (state_r)
                ST_RISE:   sys_clk_r <= new_rise;
                ST_FALL:   sys_clk_r <= old_lvl & ~old_fall;
                default:   sys_clk_r <= cur_valid_r & old_lvl;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Oscillator enables
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hf_en_r <= 1'b0;
            lf_en_r <= 1'b0;
        end else begin
            hf_en_r <= (cur_valid_r && cur_src_r == SRC_HF)
                    || (state_r != ST_IDLE && tgt_src_r == SRC_HF)
                    || (state_r == ST_IDLE && change_req && req_src == SRC_HF);
            // Old slow oscillator drops once it stops being current, unless watchdog or power-up timer is on
            lf_en_r <= (cur_valid_r && cur_src_r == SRC_LF)
                    || (state_r != ST_IDLE && tgt_src_r == SRC_LF)
                    || (state_r == ST_IDLE && change_req && req_src == SRC_LF)
                    || watchdog_enable || power_up_timer_active;
        end
    end

    // ----------------------------------------------------------------
    // Status register
    // ----------------------------------------------------------------
    always_comb begin
        osc_status_nxt = 8'h00;
        osc_status_nxt[STAT_SEC_READY] = sec_en_s ? sec_rdy_s : 1'b1;
        // Secondary source counts as not external here
        osc_status_nxt[STAT_EXT_RUN]   = cur_valid_r && cur_src_r == SRC_EXT;
        osc_status_nxt[STAT_HF_READY]  = hf_en_r & hf_run_s;
        osc_status_nxt[STAT_LF_READY]  = lf_en_r & lf_run_s;
        osc_status_nxt[STAT_HF_STABLE] = hf_en_r & hf_run_s & hf_set_s;
    end

    // Frozen mid-switch; refreshed once the new clock is active
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_status_r <= 8'h00;
        end else if (state_r == ST_IDLE || state_r == ST_UPDATE) begin
            osc_status_r <= osc_status_nxt;
        end
    end

    // secondary oscillator enable is only observed, never driven
    assign hf_osc_enable = hf_en_r;
    assign lf_osc_enable = lf_en_r;
    assign sys_clk_out   = sys_clk_r;
    assign switch_busy   = (state_r != ST_IDLE);

endmodule // scsw_core

//--- core/scsw_pkg.sv
// Constants, types and register map of the system clock switch control.
// Assumes a 250 MHz bus clock; oscillator and Timer1 logic live outside.
package scsw_pkg;

    // ----------------------------------------------------------------
    // Bus clock and timing
    // ----------------------------------------------------------------
    localparam int HCLK_PERIOD_PS   = 4000;
    localparam int HF_STARTUP_PS    = 2000000;
    // Least time: round up, never below one cycle
    localparam int HF_STARTUP_CYC_I = (HF_STARTUP_PS + HCLK_PERIOD_PS - 1) / HCLK_PERIOD_PS;
    localparam int HF_STARTUP_CYC   = (HF_STARTUP_CYC_I < 1) ? 1 : HF_STARTUP_CYC_I;
    localparam int EXT_STARTUP_EDG  = 2;
    localparam int SEC_STARTUP_EDG  = 1024;
    localparam int LF_STARTUP_EDG   = 1;
    localparam int DLY_W            = 11;

    // ----------------------------------------------------------------
    // Register map (byte addresses, one word each)
    // ----------------------------------------------------------------
    localparam logic [7:0] OSC_CONTROL_ADDR = 8'h00;
    localparam logic [7:0] OSC_STATUS_ADDR  = 8'h04;
    localparam int         ADDR_LSB_W       = 8;

    // Control fields
    localparam int         SCS_LSB        = 0;
    localparam int         INTERNAL_FREQ_SELECT_LSB       = 3;
    localparam logic [1:0] SCS_RESET      = 2'h0;
    localparam logic [3:0] INTERNAL_FREQ_SELECT_RESET     = 4'h7;

    // Status fields
    localparam int STAT_HF_STABLE   = 0;
    localparam int STAT_LF_READY    = 1;
    localparam int STAT_HF_READY    = 4;
    localparam int STAT_EXT_RUN     = 5;
    localparam int STAT_SEC_READY   = 7;

    // ----------------------------------------------------------------
    // Clock sources and switch states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SRC_EXT = 2'h0,
        SRC_SEC = 2'h1,
        SRC_HF  = 2'h2,
        SRC_LF  = 2'h3
    } scsw_src_type;

    typedef enum logic [4:0] {
        ST_IDLE    = 5'h01,
        ST_STARTUP = 5'h02,
        ST_FALL    = 5'h04,
        ST_RISE    = 5'h08,
        ST_UPDATE  = 5'h10
    } scsw_state_type;

    localparam logic [1:0] CONFIG_DEFAULT_OSC_INTERNAL = 2'h0;
    localparam logic [3:0] EXP_NONE      = 4'h0;
    localparam int         POST_W        = 9;

endpackage : scsw_pkg

//--- core/scsw_sync.sv
// Two-flop synchroniser with edge pulses for one asynchronous level.
// Assumes the input toggles no faster than a quarter of hclk.
module scsw_sync (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic async_in,
    output logic      level,
    output logic      rise,
    output logic      fall
);

    logic meta_r;
    logic sync_r;
    logic prev_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign level = sync_r;
    assign rise  = sync_r & ~prev_r;
    assign fall  = ~sync_r & prev_r;

endmodule // scsw_sync

//--- verification/scsw_props.sv
// Checker for scsw_core: bus read shape, clock pulse widths, oscillator enables.
// Assumes oscillator inputs stay below a quarter of hclk.
module scsw_props
    import scsw_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        sys_clk_out,
    input wire logic        switch_busy,
    input wire logic        hf_osc_enable,
    input wire logic        lf_osc_enable,
    input wire logic        watchdog_enable,
    input wire logic        power_up_timer_active,
    input wire logic        secondary_osc_enable
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic       rd_c;
    logic       rd_s;
    logic [9:0] hf_cnt;
    logic [2:0] q_cnt;
    assign rd_c = hsel && htrans[1] && hready && !hwrite && haddr[7:0] == OSC_CONTROL_ADDR;
    assign rd_s = hsel && htrans[1] && hready && !hwrite && haddr[7:0] == OSC_STATUS_ADDR;
    // Age of the fast oscillator enable; saturates
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) hf_cnt <= 10'h000;
        else if (!hf_osc_enable) hf_cnt <= 10'h000;
        else if (hf_cnt != 10'h3FF) hf_cnt <= hf_cnt + 10'h001;
    end
    // Idle time with Timer1 oscillator off, so status has caught up
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) q_cnt <= 3'h0;
        else if (switch_busy || secondary_osc_enable) q_cnt <= 3'h0;
        else if (q_cnt != 3'h7) q_cnt <= q_cnt + 3'h1;
    end
    ctrl_unimp_a: assert property (rd_c |=> hrdata[31:7] == 25'h0 && !hrdata[2])
        else $error("control read shows unimplemented bits");
    stat_unimp_a: assert property (rd_s |=> hrdata[31:8] == 24'h0 && hrdata[6] == 1'b0 && hrdata[3:2] == 2'h0)
        else $error("status read shows unimplemented bits");
    clk_high_min_a: assert property ($rose(sys_clk_out) |=> sys_clk_out)
        else $error("system clock high pulse of one cycle");
    clk_low_hold_a: assert property ($fell(sys_clk_out) |=> !sys_clk_out)
        else $error("system clock low pulse of one cycle");
    wd_keeps_lf_a: assert property (watchdog_enable [*4] |-> lf_osc_enable)
        else $error("slow oscillator off with watchdog on");
    power_up_timer_keeps_lf_a: assert property (power_up_timer_active [*4] |-> lf_osc_enable)
        else $error("slow oscillator off with power-up timer on");
    hf_start_busy_a: assert property (hf_cnt >= 10'd2 && hf_cnt <= 10'd400 |-> switch_busy)
        else $error("switch ended inside fast oscillator start-up");
    sec_flag_a: assert property (rd_s && q_cnt == 3'h7 |=> hrdata[7])
        else $error("secondary ready flag low while its enable is off");
    cover property ($fell(switch_busy));
    cover property (rd_s);
    cover property ($rose(lf_osc_enable));
endmodule // scsw_props

bind scsw_core scsw_props u_scsw_props (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .sys_clk_out(sys_clk_out),
    .switch_busy(switch_busy), .hf_osc_enable(hf_osc_enable), .lf_osc_enable(lf_osc_enable),
    .watchdog_enable(watchdog_enable), .power_up_timer_active(power_up_timer_active),
    .secondary_osc_enable(secondary_osc_enable)
);

//--- verification/testbench.sv
// Self-checking bench for scsw_core: register access and clock source switching.
// Assumes the design answers each bus phase and free-running oscillator models.
module testbench
    import scsw_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, ext_clk_in;
    logic        sec_osc_clk, hf_osc_clk, lf_osc_clk, hf_osc_running, hf_osc_settled;
    logic        lf_osc_running, sec_osc_ready, secondary_osc_enable, watchdog_enable;
    logic        power_up_timer_active, hf_osc_enable, lf_osc_enable, sys_clk_out, switch_busy;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans, config_default_osc;
    logic [2:0]  hsize;
    int          mismatches, checked, cyc, n;
    typedef struct packed {
        logic [7:0]  wr, ctl, msk, st;
        logic        lf;
        logic [15:0] lim;
    } scsw_row_type;
    // Write, control readback, status mask and value, slow enable, busy limit
    scsw_row_type rows [7] = '{'{8'hFE, 8'h7A, 8'h31, 8'h11, 1'b0, 16'd2000},
        '{8'h72, 8'h72, 8'h31, 8'h11, 1'b0, 16'd100}, '{8'h42, 8'h42, 8'h31, 8'h11, 1'b0, 16'd700},
        '{8'h02, 8'h02, 8'h22, 8'h02, 1'b1, 16'd400}, '{8'h7B, 8'h7B, 8'h31, 8'h11, 1'b0, 16'd2000},
        '{8'h79, 8'h79, 8'hA0, 8'h80, 1'b0, 16'd8000}, '{8'h78, 8'h78, 8'h20, 8'h20, 1'b0, 16'd300}};
    assign hready = hreadyout;
    scsw_core u_scsw_core (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .ext_clk_in(ext_clk_in), .sec_osc_clk(sec_osc_clk),
        .hf_osc_clk(hf_osc_clk), .lf_osc_clk(lf_osc_clk), .hf_osc_running(hf_osc_running),
        .hf_osc_settled(hf_osc_settled), .lf_osc_running(lf_osc_running),
        .sec_osc_ready(sec_osc_ready), .secondary_osc_enable(secondary_osc_enable),
        .watchdog_enable(watchdog_enable), .power_up_timer_active(power_up_timer_active),
        .config_default_osc(config_default_osc), .hf_osc_enable(hf_osc_enable),
        .lf_osc_enable(lf_osc_enable), .sys_clk_out(sys_clk_out), .switch_busy(switch_busy));
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    // Oscillators free-run, all slower than a quarter of hclk
    always #10 hf_osc_clk = ~hf_osc_clk;
    always #18 lf_osc_clk = ~lf_osc_clk;
    always #14 ext_clk_in = ~ext_clk_in;
    always #12 sec_osc_clk = ~sec_osc_clk;
    always @(posedge hclk) begin
        hf_osc_running <= hf_osc_enable;
        hf_osc_settled <= hf_osc_running;
        lf_osc_running <= lf_osc_enable;
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            mismatches++;
            results();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        @(posedge hclk);
        while (!hready) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (!hready) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic settle();
        n = 0;
        repeat (2) @(posedge hclk);
        while (switch_busy === 1'b1 && n < 20000) begin
            @(posedge hclk);
            n++;
        end
        repeat (6) @(posedge hclk);
    endtask
    task automatic results();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        {hsel, hwrite, hresetn, watchdog_enable, power_up_timer_active} = '0;
        {hf_osc_clk, lf_osc_clk, ext_clk_in, sec_osc_clk} = '0;
        {hf_osc_running, hf_osc_settled, lf_osc_running, htrans} = '0;
        {sec_osc_ready, secondary_osc_enable} = 2'h3;
        {haddr, hwdata, mismatches, checked, cyc} = '0;
        hsize = 3'h2;
        config_default_osc = 2'h3;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        bus(0, OSC_CONTROL_ADDR, 0);
        chk(rd, 32'h38);
        settle();
        bus(0, OSC_STATUS_ADDR, 0);
        chk(rd & 32'h20, 32'h20);
        $display("reset test done");
        foreach (rows[i]) begin
            bus(1, OSC_CONTROL_ADDR, {24'h0, rows[i].wr});
            bus(0, OSC_CONTROL_ADDR, 0);
            chk(rd, {24'h0, rows[i].ctl});
            settle();
            chk(n <= rows[i].lim, 1);
            bus(0, OSC_STATUS_ADDR, 0);
            chk(rd & rows[i].msk, rows[i].st);
            chk(lf_osc_enable, rows[i].lf);
            $display("row %0d done", i);
        end
        {secondary_osc_enable, sec_osc_ready} <= 2'h0;
        bus(1, OSC_STATUS_ADDR, 32'hFF);
        bus(1, 8'h08, 32'hFF);
        bus(0, 8'h08, 0);
        chk(rd, 0);
        bus(0, OSC_STATUS_ADDR, 0);
        chk(rd & 32'hCC, 32'h80);
        secondary_osc_enable <= 1'b1;
        repeat (8) @(posedge hclk);
        bus(0, OSC_STATUS_ADDR, 0);
        chk(rd[7], 0);
        power_up_timer_active <= 1'b1;
        repeat (8) @(posedge hclk);
        chk(lf_osc_enable, 1);
        {watchdog_enable, power_up_timer_active} <= 2'h2;
        bus(1, OSC_CONTROL_ADDR, 32'h02);
        settle();
        bus(1, OSC_CONTROL_ADDR, 32'h7A);
        settle();
        chk(lf_osc_enable, 1);
        $display("flag and keep-alive tests done");
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        bus(0, OSC_CONTROL_ADDR, 0);
        chk(rd, 32'h38);
        $display("second reset test done");
        results();
    end
endmodule // testbench
